// file: rtl/aim_monitor.sv
// Activity/inactivity monitor: registers, activity decode and timeout counter
`timescale 1ns/10ps

module aim_monitor
  import aim_pkg::*;
#(
  parameter int TICK_CYCLES = FINE_STEP_CYC
) (
  // Clock, reset, enable
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            clkEnable,
  // Register port access
  input  wire logic [15:0]     ioAddr,
  input  wire logic            ioWrite,
  input  wire logic            ioRead,
  input  wire logic [15:0]     ioWriteData,
  output logic      [15:0]     ioReadData,
  output logic                 ioReadHit,
  // Processor class strap, 1 for the 24-bit address class
  input  wire logic            sysWideAddr,
  // Activity sources
  input  wire aim_sources_type sources,
  // Status outputs
  output logic                 localAttentionOutput,
  output logic                 activityPulse
);

  // Registers
  logic [15:0]        maskReg_q;
  logic               requestActivityEnable_q;
  logic               monitorTestMode_q;
  logic               monitorEnable_q;
  logic [3:0]         coarseTimeoutField_q;
  logic [3:0]         fineTimeoutField_q;
  logic               activityLatchFlag_q;
  logic               inactivityDetectedFlag_q;
  logic               activityAfterFlag_q;
  logic               activityBeforeFlag_q;
  logic [COUNT_W-1:0] timeoutCount_q;
  logic [PRESCALE_W-1:0] prescale_q;
  logic               actSync1_q;
  logic               actSync2_q;
  logic               actSync3_q;

  // One-hot mask of the interrupt used for local attention service
  function automatic logic [15:0] serviceIrqOneHot(input logic [1:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    unique case (sel)
      2'h0: v[5]  = 1'b1;
      2'h1: v[10] = 1'b1;
      2'h2: v[11] = 1'b1;
      2'h3: v[15] = 1'b1;
    endcase
    return v;
  endfunction : serviceIrqOneHot

  // Fixed exclusions shared by request and in-service vectors
  function automatic logic [15:0] commonKeep(input logic [1:0] sel, input logic m8, input logic m7,
                                             input logic m0);
    logic [15:0] v;
    v = ~serviceIrqOneHot(sel);
    v[2] = 1'b0;
    v[8] = v[8] & ~m8;
    v[7] = v[7] & ~m7;
    v[0] = v[0] & ~m0;
    return v;
  endfunction : commonKeep

  // Mask register fields
  wire logic [1:0]  serviceInterruptSelect = maskReg_q[MSK_SVC_SEL_LSB +: 2];
  wire logic [2:0]  pmInputSelectField     = maskReg_q[MSK_PM_SEL_LSB +: 3];
  wire logic        pmInputLevelSelect     = maskReg_q[MSK_PM_LEVEL];

  // Register decode
  wire logic        ctrlHit  = (ioAddr == CTRL_PORT);
  wire logic        maskHit  = (ioAddr == MASK_PORT);
  wire logic        ctrlWr   = ioWrite && ctrlHit;
  wire logic        maskWr   = ioWrite && maskHit;

  // Interrupt request and in-service sources
  wire logic [15:0] reqKeep  = commonKeep(serviceInterruptSelect, maskReg_q[MSK_REQ8],
                                          maskReg_q[MSK_REQ7], maskReg_q[MSK_REQ0]);
  wire logic [15:0] insKeep  = commonKeep(serviceInterruptSelect, maskReg_q[MSK_INS8],
                                          maskReg_q[MSK_INS7], maskReg_q[MSK_INS0]);
  wire logic [15:0] picGate  = {11'h7FF, ~sources.picMaskBits[4:3], 3'h7};
  wire logic        reqAct   = requestActivityEnable_q
                               && |(sources.interruptRequestBits & picGate & reqKeep);
  wire logic        insAct   = |(sources.inServiceBits & insKeep);

  // Power-management input
  wire logic [2:0]  pmIndex  = pmInputSelectField + 3'h2;
  wire logic        pmValid  = (pmInputSelectField <= PM_SEL_LAST);
  wire logic        selectedPmInput = sources.pmInputs[pmIndex];
  wire logic        pmAct    = pmValid && (selectedPmInput == pmInputLevelSelect);

  // Bus and I/O sources
  wire logic        nmiAct   = ~maskReg_q[MSK_NMI] && sources.nmiOut;
  wire logic        diskAct  = ~maskReg_q[MSK_DISK] && sources.diskChipSelectEn
                               && sources.diskDataCycle;
  wire logic        pcsAct   = ~maskReg_q[MSK_CHIP_SELECT] && sources.chipSelectCycle;
  wire logic        copNarrow = sources.ioCycle && (sources.cycleAddr[15:0] >= COPROC_LO)
                               && (sources.cycleAddr[15:0] <= COPROC_HI);
  wire logic        copWide  = sources.ioCycle && sources.cycleAddr[23] && ~sources.cycleMemIo;
  wire logic        copAct   = ~maskReg_q[MSK_COPROC]
                               && (sysWideAddr ? copWide : copNarrow);

  wire logic        anyActivity = reqAct || insAct || pmAct || nmiAct || sources.dmaCycle
                                  || diskAct || pcsAct || copAct;

  // Rising edge of the synchronised activity level
  wire logic        actPulse = actSync2_q && ~actSync3_q;

  // Timeout target in fine ticks
  wire logic [COUNT_W-1:0] coarseTicks = COUNT_W'(coarseTimeoutField_q) * COUNT_W'(COARSE_STEP_TICKS);
  wire logic [COUNT_W-1:0] targetTicks = coarseTicks + COUNT_W'(fineTimeoutField_q);

  // Prescaler and counter step
  wire logic [PRESCALE_W-1:0] tickLimit = monitorTestMode_q ? PRESCALE_W'(TEST_STEP_CYC - 1)
                                                            : PRESCALE_W'(TICK_CYCLES - 1);
  wire logic        tick      = monitorEnable_q && (prescale_q == tickLimit);
  wire logic [COUNT_W-1:0] countStep = monitorTestMode_q ? COUNT_W'(1 << TEST_BYPASS_STAGES)
                                                         : COUNT_W'(1);
  wire logic [COUNT_W-1:0] countNext = timeoutCount_q + countStep;
  wire logic        timeoutHit = tick && !actPulse && (countNext >= targetTicks);

  // Control write effects
  wire logic        clearTriple = ctrlWr && (!ioWriteData[CTL_INACT_DET]
                                             || !ioWriteData[CTL_ENABLE]);
  wire logic        clearLatch  = ctrlWr && !ioWriteData[CTL_ACT_LATCH];
  wire logic        runNext     = ctrlWr ? ioWriteData[CTL_ENABLE] : monitorEnable_q;

  // Read data
  wire logic [15:0] ctrlView = {requestActivityEnable_q, timeoutCount_q[12], monitorTestMode_q,
                                activityLatchFlag_q, inactivityDetectedFlag_q, activityAfterFlag_q,
                                activityBeforeFlag_q, monitorEnable_q,
                                coarseTimeoutField_q, fineTimeoutField_q};
  wire logic [15:0] readMux  = ctrlHit ? ctrlView : (maskHit ? maskReg_q : 16'h0000);

  // Activity synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      actSync1_q <= 1'b0;
      actSync2_q <= 1'b0;
      actSync3_q <= 1'b0;
    end else if (clkEnable) begin
      actSync1_q <= anyActivity;
      actSync2_q <= actSync1_q;
      actSync3_q <= actSync2_q;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maskReg_q               <= MASK_RESET;
      requestActivityEnable_q <= CTRL_RESET[CTL_REQ_ENABLE];
      monitorTestMode_q       <= CTRL_RESET[CTL_TEST_MODE];
      monitorEnable_q         <= CTRL_RESET[CTL_ENABLE];
      coarseTimeoutField_q    <= CTRL_RESET[CTL_COARSE_LSB +: 4];
      fineTimeoutField_q      <= CTRL_RESET[CTL_FINE_LSB +: 4];
    end else if (clkEnable) begin
      if (maskWr) begin
        maskReg_q <= ioWriteData;
      end
      if (ctrlWr) begin
        requestActivityEnable_q <= ioWriteData[CTL_REQ_ENABLE];
        monitorTestMode_q       <= ioWriteData[CTL_TEST_MODE];
        monitorEnable_q         <= ioWriteData[CTL_ENABLE];
        coarseTimeoutField_q    <= ioWriteData[CTL_COARSE_LSB +: 4];
        fineTimeoutField_q      <= ioWriteData[CTL_FINE_LSB +: 4];
      end
    end
  end

  // Prescaler and timeout counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prescale_q     <= '0;
      timeoutCount_q <= '0;
    end else if (clkEnable) begin
      if (!runNext || !monitorEnable_q || actPulse || timeoutHit) begin
        prescale_q     <= '0;
        timeoutCount_q <= '0;
      end else if (tick) begin
        prescale_q     <= '0;
        timeoutCount_q <= countNext;
      end else begin
        prescale_q     <= prescale_q + PRESCALE_W'(1);
      end
    end
  end

  // Status flags; a set in the same cycle as a clear wins, except that a write clearing the enable bit blocks the inactivity set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      activityLatchFlag_q      <= 1'b0;
      inactivityDetectedFlag_q <= 1'b0;
      activityAfterFlag_q      <= 1'b0;
      activityBeforeFlag_q     <= 1'b0;
    end else if (clkEnable) begin
      activityLatchFlag_q      <= actPulse || (activityLatchFlag_q && !clearLatch);
      inactivityDetectedFlag_q <= (timeoutHit && runNext)
                                  || (inactivityDetectedFlag_q && !clearTriple);
      activityAfterFlag_q      <= (actPulse && inactivityDetectedFlag_q)
                                  || (activityAfterFlag_q && !clearTriple);
      activityBeforeFlag_q     <= (actPulse && monitorEnable_q && !inactivityDetectedFlag_q)
                                  || (activityBeforeFlag_q && !clearTriple);
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ioReadData <= 16'h0000;
      ioReadHit  <= 1'b0;
    end else if (clkEnable) begin
      ioReadHit <= ioRead && (ctrlHit || maskHit);
      if (ioRead) begin
        ioReadData <= readMux;
      end
    end
  end

  assign localAttentionOutput = inactivityDetectedFlag_q;
  assign activityPulse        = actPulse;

endmodule : aim_monitor

// file: rtl/aim_pkg.sv
// Package: constants and types of the activity/inactivity monitor
package aim_pkg;

  // Port addresses of the two registers
  localparam logic [15:0] CTRL_PORT          = 16'hB072;
  localparam logic [15:0] MASK_PORT          = 16'hD872;

  // Control register field positions
  localparam int          CTL_REQ_ENABLE     = 15;
  localparam int          CTL_COUNT_BIT12    = 14;
  localparam int          CTL_TEST_MODE      = 13;
  localparam int          CTL_ACT_LATCH      = 12;
  localparam int          CTL_INACT_DET      = 11;
  localparam int          CTL_ACT_AFTER      = 10;
  localparam int          CTL_ACT_BEFORE     = 9;
  localparam int          CTL_ENABLE         = 8;
  localparam int          CTL_COARSE_LSB     = 4;
  localparam int          CTL_FINE_LSB       = 0;

  // Mask register field positions
  localparam int          MSK_CHIP_SELECT    = 15;
  localparam int          MSK_PM_LEVEL       = 14;
  localparam int          MSK_PM_SEL_LSB     = 11;
  localparam int          MSK_NMI            = 10;
  localparam int          MSK_DISK           = 9;
  localparam int          MSK_COPROC         = 8;
  localparam int          MSK_SVC_SEL_LSB    = 6;
  localparam int          MSK_REQ8           = 5;
  localparam int          MSK_REQ7           = 4;
  localparam int          MSK_REQ0           = 3;
  localparam int          MSK_INS8           = 2;
  localparam int          MSK_INS7           = 1;
  localparam int          MSK_INS0           = 0;

  // Reset values
  localparam logic [15:0] CTRL_RESET         = 16'h0000;
  localparam logic [15:0] MASK_RESET         = 16'h0000;

  // Input select codes
  localparam logic [2:0]  PM_SEL_LAST        = 3'h5;
  localparam logic [2:0]  PM_SEL_OFF         = 3'h7;

  // Coprocessor I/O window for the 16-bit bus class
  localparam logic [15:0] COPROC_LO          = 16'h00F8;
  localparam logic [15:0] COPROC_HI          = 16'h00FF;

  // Timing: one fine step is 7812500 ns, counter ticks once per fine step outside test mode
  localparam int          CLK_PERIOD_NS      = 40;
  localparam int          FINE_STEP_NS       = 7812500;
  localparam int          FINE_STEP_CYC      = (FINE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TEST_STEP_CYC      = 16;
  localparam int          COARSE_STEP_TICKS  = 8192;
  localparam int          COUNT_W            = 17;
  localparam int          TEST_BYPASS_STAGES = 9;
  localparam int          PRESCALE_W         = 18;

  // Activity sources presented by the surrounding chipset
  typedef struct packed {
    logic [15:0] interruptRequestBits;
    logic [15:0] inServiceBits;
    logic [15:0] picMaskBits;
    logic [7:2]  pmInputs;
    logic        nmiOut;
    logic        dmaCycle;
    logic        ioCycle;
    logic [23:0] cycleAddr;
    logic        cycleMemIo;
    logic        diskDataCycle;
    logic        diskChipSelectEn;
    logic        chipSelectCycle;
  } aim_sources_type;

endpackage : aim_pkg

// file: tb/aim_checker_monitor.sv
// Port checker of the activity monitor
`timescale 1ns/10ps
module aim_checker
  import aim_pkg::*;
#(
  parameter int TICK_CYCLES = FINE_STEP_CYC
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            reset_n,
  input wire logic            clkEnable,
  // Register port
  input wire logic [15:0]     ioAddr,
  input wire logic            ioWrite,
  input wire logic            ioRead,
  input wire logic [15:0]     ioWriteData,
  input wire logic [15:0]     ioReadData,
  input wire logic            ioReadHit,
  // Sources and status
  input wire logic            sysWideAddr,
  input wire aim_sources_type sources,
  input wire logic            localAttentionOutput,
  input wire logic            activityPulse
);
  logic [15:0] maskQ;
  logic [15:0] ctlQ;
  logic [3:0]  quietQ;
  logic        attnQ;
  longint      cntQ;
  longint      tgt;
  logic        ctlWr;
  logic        idle;
  assign ctlWr = clkEnable && ioWrite && ioAddr == CTRL_PORT;
  assign idle = !(|{sources.interruptRequestBits, sources.inServiceBits, sources.nmiOut, sources.dmaCycle,
                 sources.ioCycle, sources.diskDataCycle, sources.chipSelectCycle}) && maskQ[13:11] == PM_SEL_OFF;
  assign tgt = (ctlQ[7:0] == 8'h00) ? longint'(TICK_CYCLES) :
               (longint'(ctlQ[7:4]) * COARSE_STEP_TICKS + longint'(ctlQ[3:0])) * TICK_CYCLES;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maskQ  <= MASK_RESET;
      ctlQ   <= CTRL_RESET;
      quietQ <= 4'h0;
      attnQ  <= 1'h0;
      cntQ   <= 0;
    end else if (clkEnable) begin
      if (ioWrite && ioAddr == MASK_PORT) maskQ <= ioWriteData;
      if (ctlWr) ctlQ <= ioWriteData;
      quietQ <= {quietQ[2:0], idle};
      attnQ  <= localAttentionOutput;
      cntQ   <= (ctlWr || activityPulse || (localAttentionOutput && !attnQ)) ? 0 : cntQ + 1;
    end
  end
  default clocking mainClk @(posedge clk); endclocking
  default disable iff (!reset_n || !clkEnable);
  pulse_single_a: assert property (activityPulse |=> !activityPulse)
    else $error("activity pulse longer than one cycle");
  nmi_seen_a: assert property ($rose(sources.nmiOut) && !maskQ[MSK_NMI] && &quietQ |-> ##2 activityPulse)
    else $error("unmasked nmi gave no pulse");
  nmi_masked_a: assert property ($rose(sources.nmiOut) && maskQ[MSK_NMI] && &quietQ |-> !activityPulse [*5])
    else $error("masked nmi gave a pulse");
  cascade_off_a: assert property (($rose(sources.inServiceBits[2]) ||
    $rose(sources.interruptRequestBits[2])) && &quietQ |-> !activityPulse [*5])
    else $error("cascade bit gave a pulse");
  attn_hold_a: assert property (localAttentionOutput && !ctlWr |=> localAttentionOutput)
    else $error("attention dropped without a write");
  attn_clear_a: assert property (ctlWr && !ioWriteData[CTL_ENABLE] |=> !localAttentionOutput)
    else $error("disable left attention set");
  attn_cause_a: assert property ($rose(localAttentionOutput) |-> $past(ctlQ[CTL_ENABLE]))
    else $error("attention while disabled");
  timeout_len_a: assert property ($rose(localAttentionOutput) && !ctlQ[CTL_TEST_MODE] |->
    cntQ >= tgt && cntQ <= tgt + 4)
    else $error("timeout length off");
endmodule : aim_checker

bind aim_monitor aim_checker #(.TICK_CYCLES(TICK_CYCLES)) checkInst (
  .clk(clk), .reset_n(reset_n), .clkEnable(clkEnable), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
  .ioWriteData(ioWriteData), .ioReadData(ioReadData), .ioReadHit(ioReadHit), .sysWideAddr(sysWideAddr),
  .sources(sources), .localAttentionOutput(localAttentionOutput), .activityPulse(activityPulse));

// file: tb/aim_monitor_test.sv
// Self-checking bench of the activity monitor
`timescale 1ns/10ps
module aim_monitor_test
  import aim_pkg::*;
;
  localparam int T = 8;
  logic            clk = 1'h0;
  logic            reset_n = 1'h0;
  logic            ioWrite = 1'h0;
  logic            ioRead = 1'h0;
  logic            sysWideAddr = 1'h0;
  logic            evOn = 1'h0;
  logic [5:0]      evKind = 6'h00;
  logic [15:0]     ioAddr = 16'h0000;
  logic [15:0]     ioWriteData = 16'h0000;
  logic [15:0]     ioReadData;
  logic            ioReadHit;
  logic            attn;
  logic            pulse;
  aim_sources_type sources;
  int              n_errors = 0;
  int              total_checks = 0;
  int              cycles = 0;
  always #20 clk = ~clk;
  aim_source_model MODEL (.evKind(evKind), .evOn(evOn), .sources(sources));
  aim_monitor #(.TICK_CYCLES(T)) DUT (.clk(clk), .reset_n(reset_n), .clkEnable(1'h1), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWriteData(ioWriteData), .ioReadData(ioReadData),
    .ioReadHit(ioReadHit), .sysWideAddr(sysWideAddr), .sources(sources), .localAttentionOutput(attn),
    .activityPulse(pulse));
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 ioAddr = a;
    ioWriteData = d;
    ioWrite = 1'h1;
    @(posedge clk);
    #1 ioWrite = 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m, input logic h);
    @(posedge clk);
    #1 ioAddr = a;
    ioRead = 1'h1;
    @(posedge clk);
    #1 ioRead = 1'h0;
    check((ioReadData & m) === (e & m) && ioReadHit === h, "register read");
  endtask : rd
  task automatic fire(input logic [5:0] k);
    @(posedge clk);
    #1 evKind = k;
    evOn = 1'h1;
    repeat (4) @(posedge clk);
    #1 evOn = 1'h0;
    repeat (4) @(posedge clk);
  endtask : fire
  task automatic wait_attn(input int lo, input int hi);
    int n;
    n = 0;
    while (attn !== 1'h1 && n < hi + 4) begin
      @(posedge clk);
      #1 n++;
    end
    check(n >= lo && n <= hi, "timeout length");
  endtask : wait_attn
  task automatic ev(input logic [5:0] k, input logic [15:0] m, input logic [15:0] c, input logic e);
    logic seen;
    seen = 1'h0;
    wr(CTRL_PORT, c);
    wr(MASK_PORT, m);
    sysWideAddr = (k == 6'h04);
    repeat (8) @(posedge clk);
    #1 evKind = k;
    evOn = 1'h1;
    repeat (6) begin
      @(posedge clk);
      #1 if (pulse === 1'h1) seen = 1'h1;
    end
    evOn = 1'h0;
    check(seen === e, "activity detection");
  endtask : ev
  task automatic t_reset();
    rd(CTRL_PORT, 16'h0000, 16'hBFFF, 1'h1);
    rd(MASK_PORT, 16'h0000, 16'hFFFF, 1'h1);
    rd(16'h1234, 16'h0000, 16'hFFFF, 1'h0);
    check(attn === 1'h0, "attention after reset");
  endtask : t_reset
  task automatic t_sources();
    ev(6'h01, 16'h3800, 16'h8000, 1'h1);
    ev(6'h01, 16'h3C00, 16'h8000, 1'h0);
    ev(6'h02, 16'h3800, 16'h8000, 1'h1);
    ev(6'h03, 16'h3800, 16'h8000, 1'h1);
    ev(6'h03, 16'h3900, 16'h8000, 1'h0);
    ev(6'h04, 16'h3800, 16'h8000, 1'h1);
    ev(6'h05, 16'h3800, 16'h8000, 1'h1);
    ev(6'h05, 16'h3A00, 16'h8000, 1'h0);
    ev(6'h06, 16'h3800, 16'h8000, 1'h1);
    ev(6'h06, 16'hB800, 16'h8000, 1'h0);
    ev(6'h07, 16'h2800, 16'h8000, 1'h1);
    ev(6'h07, 16'h6800, 16'h8000, 1'h0);
    ev(6'h07, 16'h3000, 16'h8000, 1'h0);
    ev(6'h07, 16'h3800, 16'h8000, 1'h0);
    ev(6'h10, 16'h3800, 16'h8000, 1'h1);
    ev(6'h10, 16'h3800, 16'h0000, 1'h0);
    ev(6'h10, 16'h3808, 16'h8000, 1'h0);
    ev(6'h27, 16'h3802, 16'h8000, 1'h0);
    ev(6'h12, 16'h3800, 16'h8000, 1'h0);
    ev(6'h22, 16'h3800, 16'h8000, 1'h0);
    ev(6'h13, 16'h3800, 16'h8000, 1'h1);
    ev(6'h30, 16'h3800, 16'h8000, 1'h0);
    ev(6'h15, 16'h3800, 16'h8000, 1'h0);
    ev(6'h15, 16'h3840, 16'h8000, 1'h1);
    ev(6'h1B, 16'h3880, 16'h8000, 1'h0);
    ev(6'h2F, 16'h38C0, 16'h8000, 1'h0);
  endtask : t_sources
  task automatic t_timeout();
    wr(CTRL_PORT, 16'h0103);
    wait_attn(3 * T, 3 * T + 2);
    rd(CTRL_PORT, 16'h0903, 16'hBFFF, 1'h1);
    fire(6'h01);
    rd(CTRL_PORT, 16'h1D03, 16'hBDFF, 1'h1);
    wr(CTRL_PORT, 16'h0F03);
    rd(CTRL_PORT, 16'h0D03, 16'hBDFF, 1'h1);
    wr(CTRL_PORT, 16'h1103);
    rd(CTRL_PORT, 16'h0103, 16'hBFFF, 1'h1);
    fire(6'h01);
    wait_attn(0, 3 * T + 2);
    rd(CTRL_PORT, 16'h1B03, 16'hBFFF, 1'h1);
    wait_attn(0, 0);
    wr(CTRL_PORT, 16'h0000);
    rd(CTRL_PORT, 16'h0000, 16'hBFFF, 1'h1);
    check(attn === 1'h0, "attention after disable");
  endtask : t_timeout
  task automatic t_long();
    wr(CTRL_PORT, 16'h2110);
    wait_attn(256, 258);
    wr(CTRL_PORT, 16'h0000);
    wr(CTRL_PORT, 16'h0111);
    wait_attn(8193 * T, 8193 * T + 2);
    wr(CTRL_PORT, 16'h0000);
  endtask : t_long
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'h1;
    t_reset();
    t_sources();
    t_timeout();
    t_long();
    finish_test();
  end
endmodule : aim_monitor_test

// file: tb/aim_source_model.sv
// Model of the chipset activity sources
`timescale 1ns/10ps
module aim_source_model
  import aim_pkg::*;
(
  // Event request
  input wire logic [5:0] evKind,
  input wire logic       evOn,
  // Sources toward the monitor
  output aim_sources_type sources
);
  always_comb begin
    sources = '0;
    sources.pmInputs = 6'h3F;
    sources.cycleMemIo = 1'h1;
    sources.cycleAddr = 24'h000100;
    if (evOn) begin
      case (evKind)
        6'h01: sources.nmiOut = 1'h1;
        6'h02: sources.dmaCycle = 1'h1;
        6'h03, 6'h04: begin
          sources.ioCycle = 1'h1;
          sources.cycleMemIo = 1'h0;
          sources.cycleAddr = (evKind == 6'h03) ? {8'h00, COPROC_LO} : 24'h800000;
        end
        6'h05: begin
          sources.diskDataCycle = 1'h1;
          sources.diskChipSelectEn = 1'h1;
        end
        6'h06: sources.chipSelectCycle = 1'h1;
        6'h07: sources.pmInputs[7] = 1'h0;
        6'h30: begin
          sources.interruptRequestBits[3] = 1'h1;
          sources.picMaskBits[3] = 1'h1;
        end
        default: begin
          sources.interruptRequestBits[evKind[3:0]] = (evKind[5:4] == 2'h1);
          sources.inServiceBits[evKind[3:0]] = (evKind[5:4] == 2'h2);
        end
      endcase
    end
  end
endmodule : aim_source_model
